// ### mutsup_pkg.sv
`default_nettype none
package mutsup_pkg;
    // Clock and timing
    localparam logic [63:0] CLK_HZ        = 64'd25_000_000;
    localparam logic [63:0] T_MSDEL_MS    = 64'd50;
    localparam logic [63:0] T_SENS_MS     = 64'd4000;
    localparam logic [63:0] T_MUTE_S      = 64'd300;
    localparam logic [63:0] T_MDO_S       = 64'd20;
    localparam logic [63:0] T_BLINK_MS    = 64'd250;
    localparam logic [63:0] MSDEL_CYC     = T_MSDEL_MS * CLK_HZ / 64'd1000;
    localparam logic [63:0] SENS_CYC      = T_SENS_MS * CLK_HZ / 64'd1000;
    localparam logic [63:0] MUTE_CYC      = T_MUTE_S * CLK_HZ;
    localparam logic [63:0] MDO_CYC       = T_MDO_S * CLK_HZ;
    localparam logic [63:0] BLINK_CYC     = T_BLINK_MS * CLK_HZ / 64'd1000;
    localparam int          DEL_W         = 21;
    localparam int          TMR_W         = 33;
    localparam int          BLK_W         = 24;

    // Register map
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_INT_STAT = 12'h008;
    localparam logic [11:0] ADDR_INT_MASK = 12'h00C;
    localparam logic [11:0] ADDR_BLINK    = 12'h010;
    localparam logic [31:0] CTRL_RST      = 32'h0000_0001;
    localparam int          CTRL_ALLOW    = 0;
    localparam logic [3:0]  INT_MASK_RST  = 4'h0;
    localparam int          EV_MUTED      = 0;
    localparam int          EV_SEQERR     = 1;
    localparam int          EV_TRIP       = 2;
    localparam int          EV_OVRD       = 3;
    localparam int          ST_SENS_LSB   = 8;
    localparam int          ST_BLOCKED    = 12;
    localparam int          ST_ERR        = 13;
    localparam int          ST_ADDON      = 14;
    localparam int          ST_CFG_OK     = 15;
    localparam int          ST_SAFETY     = 16;
    localparam int          ST_LAMP       = 17;

    // Synchroniser bit positions
    localparam int          SY_MAIN       = 0;
    localparam int          SY_CASC       = 2;
    localparam int          SY_BLOCKED    = 6;
    localparam int          NCH           = 7;
    localparam int          SY_START      = 7;
    localparam int          SY_ADDON      = 8;
    localparam int          SY_RSTMODE    = 9;
    localparam int          SY_PORT       = 10;
    localparam int          SY_TYPE       = 11;
    localparam int          SY_W          = 13;

    // Muting type switch codes
    typedef enum logic [1:0] {
        MT_OFF = 2'h0,
        MT_T2  = 2'h1,
        MT_T4  = 2'h2,
        MT_L2  = 2'h3
    } mutsup_type_e;

    typedef enum logic [5:0] {
        ST_LOCK   = 6'h01,
        ST_RUN    = 6'h02,
        ST_ARM    = 6'h04,
        ST_MUTED  = 6'h08,
        ST_SEQERR = 6'h10,
        ST_OVRD   = 6'h20
    } mutsup_state_e;
endpackage
`default_nettype wire

// ### mutsup_top.sv
`default_nettype none
// Notes on behaviour
// - While muted the safety output pair stays on even with the field interrupted.
// - A wrong sensor sequence or timing violation ends or refuses muting, and interruption then trips.
// - After a muting violation the start button acts as an override to clear material.
// - Three muting types are selectable: two-sensor T, four-sensor T and two-sensor L.
// - Four-sensor muting works only on the cascade port; two-sensor types use either port.
// - Muting needs the add-on present and takes its function from the configuration switches.
// - Each muting type can run with manual or automatic start.
// - The muting lamp is steadily on the whole time the curtain is muted.
// - After a sequence error the muting lamp blinks.
// - Sensor and interruption inputs get a 50 ms off-delay against dropouts.
// - A normal manual start is taken only with no sensor active and the field clear.
// - Override ends on its time limit or when the field clears, whichever is first.
module mutsup_top
    import mutsup_pkg::*;
#(
    parameter logic [DEL_W-1:0] P_MSDEL_CYC = DEL_W'(MSDEL_CYC),
    parameter logic [TMR_W-1:0] P_SENS_CYC  = TMR_W'(SENS_CYC),
    parameter logic [TMR_W-1:0] P_MUTE_CYC  = TMR_W'(MUTE_CYC),
    parameter logic [TMR_W-1:0] P_MDO_CYC   = TMR_W'(MDO_CYC),
    parameter logic [BLK_W-1:0] P_BLINK_CYC = BLK_W'(BLINK_CYC)
) (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [1:0]  ms_main_n_i,
    input  wire logic [3:0]  ms_casc_n_i,
    input  wire logic        field_blocked_i,
    input  wire logic        start_btn_i,
    input  wire logic        addon_present_i,
    input  wire logic        auto_start_sw_i,
    input  wire logic        casc_port_sw_i,
    input  wire logic [1:0]  mute_type_sw_i,
    output logic      [1:0]  safety_output_pair_o,
    output logic             mute_lamp_o,
    output logic             irq_o
);

    typedef struct packed {
        logic [SY_W-1:0]            sync1;
        logic [SY_W-1:0]            sync2;
        logic                       btn_prev;
        logic [NCH-1:0][DEL_W-1:0]  del_cnt;
        mutsup_state_e              state;
        logic [TMR_W-1:0]           tmr;
        logic                       seen;
        logic                       err;
        logic [BLK_W-1:0]           blink_cnt;
        logic                       blink;
        logic                       allow;
        logic [BLK_W-1:0]           blink_per;
        logic [3:0]                 int_stat;
        logic [3:0]                 int_mask;
        logic [31:0]                prdata;
        logic                       safety;
        logic                       lamp;
    } mutsup_regs_s;

    mutsup_regs_s s_q;
    mutsup_regs_s s_d;

    logic [NCH-1:0]            act_raw;
    logic [NCH-1:0]            act;
    logic [NCH-1:0][DEL_W-1:0] cnt_nx;

    assign act_raw = {s_q.sync2[SY_BLOCKED], ~s_q.sync2[SY_CASC +: 4], ~s_q.sync2[SY_MAIN +: 2]};

    // off-delay filter
    // Activation is taken at once; release waits the full delay so dropouts are bridged.
    for (genvar i = 0; i < NCH; i++)
    begin : g_del
        assign act[i]    = act_raw[i] | (s_q.del_cnt[i] != '0);
        assign cnt_nx[i] = act_raw[i] ? P_MSDEL_CYC
                         : (s_q.del_cnt[i] != '0) ? s_q.del_cnt[i] - DEL_W'(1) : '0;
    end

    mutsup_type_e      mtype;
    logic              cfg_ok;
    logic              casc;
    logic [3:0]        sens;
    logic [3:0]        need;
    logic              any_act;
    logic              all_act;
    logic              blocked;
    logic              start_ev;
    logic              apb_setup;
    logic              apb_wr;
    logic              mapped;
    logic [3:0]        ev;
    logic [BLK_W-1:0]  per;

    always_comb
    begin
        mtype = mutsup_type_e'(s_q.sync2[SY_TYPE +: 2]);
        casc  = s_q.sync2[SY_PORT];
        sens  = casc ? act[SY_CASC +: 4] : {2'b00, act[SY_MAIN +: 2]};
        need  = (mtype == MT_T4) ? 4'hF : 4'h3;
        cfg_ok = s_q.sync2[SY_ADDON] & s_q.allow & (mtype != MT_OFF)
               & !((mtype == MT_T4) & !casc);
        any_act  = |(sens & need);
        all_act  = (sens & need) == need;
        blocked  = act[SY_BLOCKED];
        // Rising edge only, so a held button acts once
        start_ev = s_q.sync2[SY_START] & ~s_q.btn_prev;
        apb_setup = psel_i & ~penable_i;
        apb_wr    = psel_i & penable_i & pwrite_i;
        mapped = (paddr_i == ADDR_CTRL) | (paddr_i == ADDR_STATUS)
               | (paddr_i == ADDR_INT_STAT) | (paddr_i == ADDR_INT_MASK)
               | (paddr_i == ADDR_BLINK);
        // A zero period would stall the blink, so it counts as one
        per = (s_q.blink_per == '0) ? BLK_W'(1) : s_q.blink_per;
    end

    always_comb
    begin
        s_d = s_q;
        ev  = 4'h0;
        s_d.sync1    = {mute_type_sw_i, casc_port_sw_i, auto_start_sw_i, addon_present_i,
                        start_btn_i, field_blocked_i, ms_casc_n_i, ms_main_n_i};
        s_d.sync2    = s_q.sync1;
        s_d.btn_prev = s_q.sync2[SY_START];
        s_d.del_cnt  = cnt_nx;
        // Saturating, so a long hold never wraps back under a limit
        s_d.tmr      = (s_q.tmr == '1) ? s_q.tmr : s_q.tmr + TMR_W'(1);

        case (s_q.state)
            ST_LOCK:
            begin
                if (s_q.err && blocked && start_ev && cfg_ok)
                begin
                    s_d.state = ST_OVRD;
                    s_d.tmr   = '0;
                    ev[EV_OVRD] = 1'b1;
                end
                // auto start leaves the muting reset to the relay
                else if (!blocked && !any_act && (start_ev || s_q.sync2[SY_RSTMODE]))
                begin
                    s_d.state = ST_RUN;
                    s_d.err   = 1'b0;
                end
            end
            ST_RUN:
            begin
                if (blocked)
                begin
                    s_d.state = ST_LOCK;
                    ev[EV_TRIP] = 1'b1;
                end
                else if (cfg_ok && any_act)
                begin
                    s_d.state = ST_ARM;
                    s_d.tmr   = '0;
                end
            end
            ST_ARM:
            begin
                if (all_act && cfg_ok)
                begin
                    s_d.state = ST_MUTED;
                    s_d.tmr   = '0;
                    s_d.seen  = 1'b0;
                    ev[EV_MUTED] = 1'b1;
                end
                // sequence or t_sens violation refuses muting
                else if (blocked || !cfg_ok || s_q.tmr >= P_SENS_CYC)
                begin
                    s_d.state = ST_SEQERR;
                    s_d.err   = 1'b1;
                    ev[EV_SEQERR] = 1'b1;
                end
                else if (!any_act)
                    s_d.state = ST_RUN;
            end
            ST_MUTED:
            begin
                s_d.seen = s_q.seen | blocked;
                if (!cfg_ok || s_q.tmr >= P_MUTE_CYC || (blocked && !all_act))
                begin
                    s_d.state = ST_SEQERR;
                    s_d.err   = 1'b1;
                    ev[EV_SEQERR] = 1'b1;
                end
                else if ((mtype == MT_L2) ? (s_q.seen && !blocked) : (!any_act && !blocked))
                    s_d.state = ST_RUN;
            end
            ST_SEQERR:
            begin
                if (blocked)
                begin
                    s_d.state = ST_LOCK;
                    ev[EV_TRIP] = 1'b1;
                end
                else if (!any_act)
                begin
                    s_d.state = ST_RUN;
                    s_d.err   = 1'b0;
                end
            end
            ST_OVRD:
            begin
                // override ends on time or clear field
                if (!blocked || s_q.tmr >= P_MDO_CYC)
                    s_d.state = ST_LOCK;
            end
            default:
                s_d.state = ST_LOCK;
        endcase

        // Only the locked state switches the outputs off
        s_d.safety = (s_d.state != ST_LOCK);

        if (s_q.blink_cnt >= per - BLK_W'(1))
        begin
            s_d.blink_cnt = '0;
            s_d.blink     = ~s_q.blink;
        end
        else
            s_d.blink_cnt = s_q.blink_cnt + BLK_W'(1);
        // blinking lamp after a sequence error
        s_d.lamp = (s_d.state == ST_MUTED) | (s_d.err & s_q.blink);

        if (apb_wr)
        begin
            case (paddr_i)
                ADDR_CTRL:     s_d.allow     = pwdata_i[CTRL_ALLOW];
                ADDR_INT_STAT: s_d.int_stat  = s_q.int_stat & ~pwdata_i[3:0];
                ADDR_INT_MASK: s_d.int_mask  = pwdata_i[3:0];
                ADDR_BLINK:    s_d.blink_per = pwdata_i[BLK_W-1:0];
                default:       s_d.allow     = s_q.allow;
            endcase
        end
        // Set wins over a same-cycle clear
        s_d.int_stat = s_d.int_stat | ev;

        if (apb_setup)
        begin
            case (paddr_i)
                ADDR_CTRL:     s_d.prdata = {31'h0, s_q.allow};
                ADDR_STATUS:   s_d.prdata = {14'h0, s_q.lamp, s_q.safety, cfg_ok,
                                             s_q.sync2[SY_ADDON], s_q.err, blocked,
                                             sens, 2'b00, s_q.state};
                ADDR_INT_STAT: s_d.prdata = {28'h0, s_q.int_stat};
                ADDR_INT_MASK: s_d.prdata = {28'h0, s_q.int_mask};
                ADDR_BLINK:    s_d.prdata = {{(32-BLK_W){1'b0}}, s_q.blink_per};
                default:       s_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_q           <= '0;
            s_q.state     <= ST_LOCK;
            s_q.allow     <= CTRL_RST[CTRL_ALLOW];
            s_q.blink_per <= P_BLINK_CYC;
            s_q.int_mask  <= INT_MASK_RST;
            // Sensor contacts idle closed; avoids a false activation after reset
            s_q.sync1[SY_MAIN +: 2] <= 2'h3;
            s_q.sync1[SY_CASC +: 4] <= 4'hf;
            s_q.sync2[SY_MAIN +: 2] <= 2'h3;
            s_q.sync2[SY_CASC +: 4] <= 4'hf;
        end
        else
            s_q <= s_d;
    end

    assign prdata_o             = s_q.prdata;
    // Registers answer at once, so no wait states
    assign pready_o             = 1'b1;
    // Unmapped addresses read zero and flag an error
    assign pslverr_o            = psel_i & penable_i & ~mapped;
    assign safety_output_pair_o = {2{s_q.safety}};
    assign mute_lamp_o          = s_q.lamp;
    // Level interrupt, held until software clears the status bit
    assign irq_o                = |(s_q.int_stat & s_q.int_mask);

endmodule
`default_nettype wire

// ### mutsup_monitor.sv
`default_nettype none
module mutsup_monitor
    import mutsup_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        start_btn_i,
    input wire logic        auto_start_sw_i,
    input wire logic [1:0]  safety_output_pair_o,
    input wire logic        mute_lamp_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       acc;
    logic       rd;
    logic       bad;
    logic [3:0] mask_q;
    logic [3:0] since_q;
    assign acc = psel_i && penable_i;
    assign rd  = acc && !pwrite_i;
    assign bad = !(paddr_i inside {ADDR_CTRL, ADDR_STATUS, ADDR_INT_STAT, ADDR_INT_MASK,
                                   ADDR_BLINK});
    // Saturating count since the button was last seen high
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mask_q  <= 4'h0;
            since_q <= 4'hf;
        end
        else
        begin
            if (acc && pwrite_i && paddr_i == ADDR_INT_MASK)
                mask_q <= pwdata_i[3:0];
            since_q <= start_btn_i ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    ready_high_a: assert property (pready_o) else $error("pready low");
    bad_addr_err_a: assert property (acc |-> pslverr_o == bad) else $error("pslverr wrong");
    bad_addr_zero_a: assert property (rd && bad |-> prdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    pair_equal_a: assert property (safety_output_pair_o[0] == safety_output_pair_o[1])
        else $error("safety bits differ");
    irq_masked_a: assert property (mask_q == 4'h0 |-> !irq_o) else $error("irq while masked");
    start_before_on_a: assert property (
        $rose(safety_output_pair_o[0]) && !auto_start_sw_i |-> since_q < 4'hc)
        else $error("outputs on without start");
    status_mirror_a: assert property (rd && paddr_i == ADDR_STATUS |->
        prdata_o[31:16] == {14'h0000, $past(mute_lamp_o), $past(safety_output_pair_o[0])})
        else $error("status output bits wrong");
    ctrl_reserved_a: assert property (rd && paddr_i == ADDR_CTRL |->
        prdata_o[31:1] == 31'h0000_0000) else $error("ctrl reserved bits set");
endmodule
`default_nettype wire

// ### mutsup_partner.sv
`default_nettype none
module mutsup_partner (
    input  wire logic       mclk_i,
    output logic      [1:0] ms_main_n_o,
    output logic      [3:0] ms_casc_n_o,
    output logic            field_blocked_o,
    output logic            start_btn_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        ms_main_n_o = 2'h3;
        ms_casc_n_o = 4'hf;
        field_blocked_o = 1'b0;
        start_btn_o = 1'b0;
    end
    task automatic set_pins(input logic [1:0] m, input logic [3:0] c, input logic b);
        @(posedge mclk_i);
        ms_main_n_o <= m;
        ms_casc_n_o <= c;
        field_blocked_o <= b;
    endtask
    task automatic press();
        @(posedge mclk_i);
        start_btn_o <= 1'b1;
        repeat (3) @(posedge mclk_i);
        start_btn_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### muting_supervisor_tb.sv
`default_nettype none
module muting_supervisor_tb
    import mutsup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic        mclk, rstn, psel, penable, pwrite, start, blocked, addon, auto, casc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, m;
    logic        pready, pslverr, lamp, irq, l;
    logic [1:0]  main_n, mtype, safety;
    logic [3:0]  casc_n;
    logic [63:0] q[$];
    logic [63:0] n;
    int          n_errors, checks_done, cyc, k, i;
    mutsup_top #(.P_MSDEL_CYC(4), .P_SENS_CYC(50), .P_MUTE_CYC(200), .P_MDO_CYC(100),
        .P_BLINK_CYC(3)) i_dut (.mclk_i(mclk), .resetn_i(rstn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ms_main_n_i(main_n),
        .ms_casc_n_i(casc_n), .field_blocked_i(blocked), .start_btn_i(start),
        .addon_present_i(addon), .auto_start_sw_i(auto), .casc_port_sw_i(casc),
        .mute_type_sw_i(mtype), .safety_output_pair_o(safety), .mute_lamp_o(lamp), .irq_o(irq));
    mutsup_partner i_part (.mclk_i(mclk), .ms_main_n_o(main_n), .ms_casc_n_o(casc_n),
        .field_blocked_o(blocked), .start_btn_o(start));
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        checks_done++;
        if (a !== e)
        begin
            $display("[ERR] %0t got %h exp %h", $time, a, e);
            n_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk);
        q.push_back({mk, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge mclk);
    endtask
    // Read results are matched in issue order
    always @(posedge mclk)
    begin
        cyc++;
        if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0)
        begin
            n = q.pop_front();
            chk(prdata & n[63:32], n[31:0]);
        end
        if (cyc == 8000)
        begin
            n_errors++;
            close_out();
        end
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, rstn, auto, casc} = '0;
        addon = 1'b1;
        mtype = MT_T2;
        void'($urandom(83));
        wt(10);
        rstn <= 1'b1;
        wt(4);
        rd(ADDR_CTRL, CTRL_RST, ALL);
        rd(ADDR_INT_MASK, 32'h0000_0000, ALL);
        rd(ADDR_INT_STAT, 32'h0000_0000, ALL);
        rd(12'h014, 32'h0000_0000, ALL);
        rd(ADDR_STATUS, 32'h0000_c001, ALL);
        i_part.set_pins(2'h2, 4'hf, 1'b0);
        wt(10);
        i_part.press();
        wt(12);
        chk(32'(safety), 32'h0000_0000);
        i_part.set_pins(2'h3, 4'hf, 1'b0);
        wt(12);
        i_part.press();
        wt(12);
        chk(32'(safety), 32'h0000_0003);
        m = $urandom;
        apb(1'b1, ADDR_INT_MASK, {28'h000_0000, m[3:0]});
        rd(ADDR_INT_MASK, {28'h000_0000, m[3:0]}, ALL);
        apb(1'b1, ADDR_INT_MASK, 32'h0000_0001);
        i_part.set_pins(2'h2, 4'hf, 1'b0);
        wt(10);
        i_part.set_pins(2'h0, 4'hf, 1'b0);
        wt(10);
        i_part.set_pins(2'h0, 4'hf, 1'b1);
        wt(12);
        chk({29'h0, safety, lamp}, 32'h0000_0007);
        // Dropout kept below the four-cycle off-delay
        i_part.set_pins(2'h1, 4'hf, 1'b1);
        wt(1 + $urandom % 2);
        i_part.set_pins(2'h0, 4'hf, 1'b1);
        wt(12);
        chk({29'h0, safety, lamp, irq}, 32'h0000_000f);
        apb(1'b1, ADDR_INT_STAT, 32'h0000_0001);
        wt(2);
        chk(32'(irq), 32'h0000_0000);
        i_part.set_pins(2'h0, 4'hf, 1'b0);
        wt(12);
        i_part.set_pins(2'h3, 4'hf, 1'b0);
        wt(12);
        chk({29'h0, safety, lamp}, 32'h0000_0006);
        apb(1'b1, ADDR_BLINK, 32'h0000_0005);
        i_part.set_pins(2'h2, 4'hf, 1'b0);
        wt(10);
        i_part.set_pins(2'h2, 4'hf, 1'b1);
        wt(12);
        chk(32'(safety), 32'h0000_0000);
        for (i = 0; i < 2; i++)
        begin
            k = 0;
            l = lamp;
            while (lamp === l && k < 40)
            begin
                @(posedge mclk);
                k++;
            end
        end
        chk(32'(k), 32'h0000_0005);
        i_part.press();
        wt(12);
        chk(32'(safety), 32'h0000_0003);
        wt(100);
        chk(32'(safety), 32'h0000_0000);
        i_part.press();
        wt(12);
        i_part.set_pins(2'h2, 4'hf, 1'b0);
        wt(12);
        chk(32'(safety), 32'h0000_0000);
        i_part.set_pins(2'h3, 4'hf, 1'b0);
        wt(12);
        i_part.press();
        wt(12);
        chk(32'(safety), 32'h0000_0003);
        rd(ADDR_INT_STAT, 32'h0000_000e, 32'h0000_000e);
        for (i = 0; i < 6; i++)
        begin
            @(posedge mclk);
            mtype <= 2'(i % 3 + 1);
            casc <= (i >= 3);
            wt(8);
            rd(ADDR_STATUS, (i == 1) ? 32'h0000_4000 : 32'h0000_c000, 32'h0000_c000);
        end
        addon <= 1'b0;
        wt(8);
        rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_4000);
        addon <= 1'b1;
        auto <= 1'b1;
        i_part.set_pins(2'h3, 4'hf, 1'b1);
        wt(12);
        chk(32'(safety), 32'h0000_0000);
        i_part.set_pins(2'h3, 4'hf, 1'b0);
        wt(12);
        chk(32'(safety), 32'h0000_0003);
        // Exit-side muting on the cascade port ends when the field clears
        i_part.set_pins(2'h3, 4'hc, 1'b0);
        wt(10);
        i_part.set_pins(2'h3, 4'hc, 1'b1);
        wt(12);
        chk({29'h0, safety, lamp}, 32'h0000_0007);
        i_part.set_pins(2'h3, 4'hf, 1'b0);
        wt(12);
        chk({29'h0, safety, lamp}, 32'h0000_0006);
        close_out();
    end
endmodule
bind mutsup_top mutsup_monitor i_mon (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .start_btn_i(start_btn_i),
    .auto_start_sw_i(auto_start_sw_i), .safety_output_pair_o(safety_output_pair_o),
    .mute_lamp_o(mute_lamp_o), .irq_o(irq_o));
`default_nettype wire
